// file: ecd_regs.vh
// Register indices, codes and timing constants for the external sample clock divider.
// How it works
// - Divided-external mode divides the external clock input.
// - Divisor even, step two, at most 8190.
// - Band codes: 64 slow, 128 fast.
// - Band boundary follows active channels per module.
// - Slow band tolerates gaps, resumes on edges.
// - External or divided clock reaches converters resampled on pclk, not directly.
// - Termination on only while connector is input.
`ifndef ECD_REGS_VH
`define ECD_REGS_VH
`define ECD_AW 20
`define ECD_IDX_CLOCK_MODE 20'd20200
`define ECD_IDX_CLOCK_DIV 20'd20040
`define ECD_IDX_EXT_BAND 20'd20130
`define ECD_IDX_TERM 20'd20120
`define ECD_IDX_CHAN_MASK 20'd20300
`define ECD_IDX_STATUS 20'd20310
`define ECD_MODE_DIVIDED 32'h0000_0010
`define ECD_MODE_DIRECT 32'h0000_0020
`define ECD_BAND_SLOW 32'h0000_0040
`define ECD_BAND_FAST 32'h0000_0080
`define ECD_DIV_MAX 32'h0000_1ffe
`define ECD_DIV_MIN 32'h0000_0002
`define ECD_RST_MODE 32'h0000_0000
`define ECD_RST_DIV 32'h0000_0002
`define ECD_RST_BAND 32'h0000_0040
`define ECD_RST_MASK 8'h01
`define ECD_PCLK_KHZ 250000
`define ECD_EDGE_KHZ_1 50000
`define ECD_EDGE_KHZ_2 25000
`define ECD_EDGE_KHZ_4 12500
`define ECD_EDGE_KHZ_8 6000
// Boundary periods in pclk cycles; ECD_PER_8 is rounded down from 41.67, so a clock at that boundary rate can count as slow.
`define ECD_PER_1 16'h0005
`define ECD_PER_2 16'h000a
`define ECD_PER_4 16'h0014
`define ECD_PER_8 16'h0029
`define ECD_GAP_CYCLES 16'h1000
`define ECD_ST_PRESENT 16
`define ECD_ST_FAST_EXP 17
`define ECD_ST_MISMATCH 18
`define ECD_ST_GAP_FAST 19
`endif

// file: ecd_edge_divider.v
// Synchroniser and edge-counting divider that forms the converter sample clock.
`timescale 1ns/100ps
module ecd_edge_divider
(
  input wire pclk,
  input wire presetn,
  input wire ext_clk_in,
  input wire divided_mode,
  input wire direct_mode,
  input wire [11:0] half_div,
  output reg sample_clk_reg,
  output reg sample_edge_reg
);
  reg sync1_reg;
  reg sync2_reg;
  reg prev_reg;
  reg [11:0] cnt_reg;
  wire rise;

  assign rise = sync2_reg & ~prev_reg;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      cnt_reg <= 12'h000;
      sample_clk_reg <= 1'b0;
      sample_edge_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= ext_clk_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      sample_edge_reg <= 1'b0;
      if (direct_mode)
      begin
        // The input level is passed on with no regeneration stage.
        sample_clk_reg <= sync2_reg;
        sample_edge_reg <= rise;
        cnt_reg <= 12'h000;
      end
      else if (divided_mode)
      begin
        // Only input edges advance the count, so a gap simply pauses the output.
        if (rise)
        begin
          if (cnt_reg >= half_div - 12'h001)
          begin
            cnt_reg <= 12'h000;
            sample_clk_reg <= ~sample_clk_reg;
            sample_edge_reg <= ~sample_clk_reg;
          end
          else
          begin
            cnt_reg <= cnt_reg + 12'h001;
          end
        end
      end
      else
      begin
        cnt_reg <= 12'h000;
        sample_clk_reg <= 1'b0;
      end
    end
  end
endmodule // ecd_edge_divider

// file: ecd_clock_ctrl.v
// APB register file and external sample clock control top.
`timescale 1ns/100ps
`include "ecd_regs.vh"
module ecd_clock_ctrl
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ECD_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ext_clk_in,
  output reg sample_clk_out,
  output reg clock_term_en
);
  reg [31:0] mode_reg;
  reg [31:0] div_reg;
  reg [31:0] band_reg;
  reg term_reg;
  reg [7:0] chan_mask_reg;
  reg [15:0] period_cnt_reg;
  reg [15:0] period_reg;
  reg present_reg;
  reg gap_fast_reg;
  reg [3:0] ones;
  reg [15:0] limit;
  reg [31:0] rd_next;
  reg hit_next;
  wire div_clk;
  wire div_edge;
  wire divided_mode;
  wire direct_mode;
  wire fast_exp;
  wire mismatch;
  wire setup_ph;
  wire wr_acc;
  wire div_ok;
  wire band_ok;
  wire [31:0] status;
  integer i;

  assign divided_mode = (mode_reg == `ECD_MODE_DIVIDED);
  assign direct_mode = (mode_reg == `ECD_MODE_DIRECT);
  assign setup_ph = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  // Odd, zero and over-range values never reach the divider.
  assign div_ok = ~pwdata[0] && (pwdata >= `ECD_DIV_MIN) && (pwdata <= `ECD_DIV_MAX);
  assign band_ok = (pwdata == `ECD_BAND_SLOW) || (pwdata == `ECD_BAND_FAST);

  ecd_edge_divider u_div
  (
    .pclk(pclk),
    .presetn(presetn),
    .ext_clk_in(ext_clk_in),
    .divided_mode(divided_mode),
    .direct_mode(direct_mode),
    .half_div(div_reg[12:1]),
    .sample_clk_reg(div_clk),
    .sample_edge_reg(div_edge)
  );

  // Boundary period in pclk cycles for the active channel count.
  always @*
  begin
    ones = 4'h0;
    for (i = 0; i < 8; i = i + 1)
      ones = ones + {3'h0, chan_mask_reg[i]};
    if (ones <= 4'h1)
      limit = `ECD_PER_1;
    else if (ones == 4'h2)
      limit = `ECD_PER_2;
    else if (ones <= 4'h4)
      limit = `ECD_PER_4;
    else
      limit = `ECD_PER_8;
  end

  // The band is judged at the divider output, as software is told to set it.
  assign fast_exp = present_reg && (period_reg <= limit);
  assign mismatch = present_reg && ((band_reg == `ECD_BAND_FAST) != fast_exp);
  assign status = {12'h000, gap_fast_reg, mismatch, fast_exp, present_reg, period_reg};

  always @*
  begin
    hit_next = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      `ECD_IDX_CLOCK_MODE * 20'd4: rd_next = mode_reg;
      `ECD_IDX_CLOCK_DIV * 20'd4: rd_next = div_reg;
      `ECD_IDX_EXT_BAND * 20'd4: rd_next = band_reg;
      `ECD_IDX_TERM * 20'd4: rd_next = {31'h0000_0000, term_reg};
      `ECD_IDX_CHAN_MASK * 20'd4: rd_next = {24'h00_0000, chan_mask_reg};
      `ECD_IDX_STATUS * 20'd4: rd_next = status;
      default: hit_next = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mode_reg <= `ECD_RST_MODE;
      div_reg <= `ECD_RST_DIV;
      band_reg <= `ECD_RST_BAND;
      term_reg <= 1'b0;
      chan_mask_reg <= `ECD_RST_MASK;
    end
    else
    begin
      // Decoding in the setup cycle lets every access finish with no wait state.
      pready <= 1'b1;
      if (setup_ph)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_next;
        pslverr <= ~hit_next;
      end
      if (wr_acc && hit_next)
      begin
        case (paddr)
          `ECD_IDX_CLOCK_MODE * 20'd4: mode_reg <= pwdata;
          `ECD_IDX_CLOCK_DIV * 20'd4: if (div_ok) div_reg <= pwdata;
          `ECD_IDX_EXT_BAND * 20'd4: if (band_ok) band_reg <= pwdata;
          `ECD_IDX_TERM * 20'd4: term_reg <= pwdata[0];
          `ECD_IDX_CHAN_MASK * 20'd4: chan_mask_reg <= pwdata[7:0];
          default: term_reg <= term_reg;
        endcase
      end
    end
  end

  // Divider output period measurement and gap watch.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      period_cnt_reg <= 16'h0000;
      period_reg <= 16'hffff;
      present_reg <= 1'b0;
      gap_fast_reg <= 1'b0;
      sample_clk_out <= 1'b0;
      clock_term_en <= 1'b0;
    end
    else
    begin
      sample_clk_out <= div_clk;
      // Termination only makes sense while the connector takes a clock in.
      clock_term_en <= term_reg & (divided_mode | direct_mode);
      if (div_edge)
      begin
        // Saturate so that a very long gap never reads back as a short period.
        period_reg <= (period_cnt_reg == 16'hffff) ? 16'hffff : period_cnt_reg + 16'h0001;
        period_cnt_reg <= 16'h0000;
        present_reg <= 1'b1;
      end
      else
      begin
        if (period_cnt_reg != 16'hffff)
          period_cnt_reg <= period_cnt_reg + 16'h0001;
        if (period_cnt_reg == `ECD_GAP_CYCLES)
        begin
          present_reg <= 1'b0;
          // A gap is legal in the slow band but is recorded for the fast one.
          if (band_reg == `ECD_BAND_FAST)
            gap_fast_reg <= 1'b1;
        end
      end
      if (wr_acc && paddr == `ECD_IDX_STATUS * 20'd4 && pwdata[`ECD_ST_GAP_FAST] && !(div_edge == 1'b0 &&
          period_cnt_reg == `ECD_GAP_CYCLES && band_reg == `ECD_BAND_FAST))
        gap_fast_reg <= 1'b0;
    end
  end
endmodule // ecd_clock_ctrl

// file: ecd_ext_clk_src.sv
// Behavioural external clock source feeding the clock connector.
`timescale 1ns/100ps
module ecd_ext_clk_src
(
  input wire logic run,
  output logic ext_clk
);
  // The source parks low between bursts, so a gap really carries no edges.
  // A 0.1 ns phase offset keeps every edge off the pclk edges, so sampling never races.
  initial
  begin
    ext_clk = 1'b0;
    #0.1;
    forever
    begin
      #10.2;
      ext_clk = run ? ~ext_clk : 1'b0;
    end
  end
endmodule // ecd_ext_clk_src

// file: ecd_clock_ctrl_properties.sv
// Port checker for the external sample clock divider.
`timescale 1ns/100ps
`include "ecd_regs.vh"
module ecd_clock_ctrl_properties
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ECD_AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ext_clk_in,
  input wire sample_clk_out,
  input wire clock_term_en
);
  localparam [19:0] AM = `ECD_IDX_CLOCK_MODE*4, AD = `ECD_IDX_CLOCK_DIV*4;
  localparam [19:0] AB = `ECD_IDX_EXT_BAND*4, AT = `ECD_IDX_TERM*4;
  reg [31:0] mode_sh, div_sh, band_sh;
  reg [7:0] eh;
  reg t_sh, te_q;
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit = paddr inside {AM, AD, AB, AT, `ECD_IDX_CHAN_MASK*4, `ECD_IDX_STATUS*4};
  wire ok = mode_sh == `ECD_MODE_DIVIDED || mode_sh == `ECD_MODE_DIRECT;
  wire te = ok && t_sh;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_sh <= 32'h0;
      div_sh <= 32'h2;
      band_sh <= 32'h40;
      t_sh <= 1'b0;
      te_q <= 1'b0;
      eh <= 8'h0;
    end
    else
    begin
      if (wr && paddr == AM) mode_sh <= pwdata;
      if (wr && paddr == AD && !pwdata[0] && pwdata != 0 && pwdata <= `ECD_DIV_MAX) div_sh <= pwdata;
      if (wr && paddr == AB && (pwdata == 32'h40 || pwdata == 32'h80)) band_sh <= pwdata;
      if (wr && paddr == AT) t_sh <= pwdata[0];
      te_q <= te;
      eh <= {eh[6:0], ext_clk_in};
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_in_access: assert property (acc |-> pready) else $error("pready low in access");
  chk_err_unmapped: assert property (acc && !hit |-> pslverr) else $error("no error for unmapped");
  chk_err_mapped: assert property (acc && hit |-> !pslverr) else $error("error on mapped register");
  chk_div_readback: assert property (acc && !pwrite && paddr == AD |-> prdata == div_sh)
    else $error("divisor readback wrong");
  chk_band_readback: assert property (acc && !pwrite && paddr == AB |-> prdata == band_sh)
    else $error("band readback wrong");
  chk_mode_readback: assert property (acc && !pwrite && paddr == AM |-> prdata == mode_sh)
    else $error("mode readback wrong");
  chk_term_follows: assert property (te == te_q |-> clock_term_en == te)
    else $error("termination state wrong");
  chk_out_quiet: assert property ((!ok) [*8] |-> !sample_clk_out) else $error("output runs while off");
  chk_edge_cause: assert property (ok && $changed(sample_clk_out) |-> eh[7:1] != eh[6:0])
    else $error("output moved without input edge");
  cover property (wr && paddr == AD);
  cover property (acc && !hit);
  cover property ($rose(clock_term_en));
  cover property ($rose(sample_clk_out));
endmodule // ecd_clock_ctrl_properties
bind ecd_clock_ctrl ecd_clock_ctrl_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ext_clk_in(ext_clk_in), .sample_clk_out(sample_clk_out), .clock_term_en(clock_term_en));

// file: ecd_clock_ctrl_tb_top.sv
// Self-checking bench for the external sample clock divider.
`timescale 1ns/100ps
`include "ecd_regs.vh"
module ecd_clock_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, run, pready, pslverr, ext_clk, sclk, term, er;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int fails, tests_run, rises, n0;
  localparam [19:0] AM = `ECD_IDX_CLOCK_MODE*4, AD = `ECD_IDX_CLOCK_DIV*4;
  localparam [19:0] AB = `ECD_IDX_EXT_BAND*4, AT = `ECD_IDX_TERM*4;
  localparam [19:0] AC = `ECD_IDX_CHAN_MASK*4, AS = `ECD_IDX_STATUS*4;
  // Input rises seen in 1000 cycles with a 20.4 ns source period.
  localparam int INR = 196;
  logic [19:0] ra[5] = '{AM, AD, AB, AT, AC};
  logic [31:0] rv[5] = '{32'h0, 32'h2, 32'h40, 32'h0, 32'h1};
  logic [31:0] dw[7] = '{32'h1ffe, 32'h7, 32'h0, 32'h2000, 32'h4, 32'h80, 32'h64};
  logic [31:0] de[7] = '{32'h1ffe, 32'h1ffe, 32'h1ffe, 32'h1ffe, 32'h4, 32'h80, 32'h80};
  ecd_clock_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk), .sample_clk_out(sclk), .clock_term_en(term));
  ecd_ext_clk_src src (.run(run), .ext_clk(ext_clk));
  always @(posedge sclk) rises++;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for pready.
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic ratio(input logic [31:0] m, input logic [31:0] dv, input int r);
    xfer(1, AM, m);
    xfer(1, AD, dv);
    repeat (40) @(posedge pclk);
    n0 = rises;
    repeat (1000) @(posedge pclk);
    chk("sample rises", 1, (rises - n0) inside {[INR/r-2:INR/r+2]});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    $display("[ERR] run time expected under 100000 ns seen timeout");
    fails++;
    give_verdict();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    run <= 1'b1;
    foreach (ra[i])
    begin
      xfer(0, ra[i], 0);
      chk("reset value", rv[i], rd);
    end
    $display("test reset values done");
    foreach (dw[i])
    begin
      xfer(1, i < 5 ? AD : AB, dw[i]);
      xfer(0, i < 5 ? AD : AB, 0);
      chk("divisor or band", de[i], rd);
      chk("mapped error", 0, er);
    end
    xfer(1, 20'h00004, 1);
    chk("unmapped error", 1, er);
    $display("test register writes done");
    xfer(1, AT, 1);
    repeat (4) @(posedge pclk);
    chk("term while off", 0, term);
    xfer(1, AM, `ECD_MODE_DIVIDED);
    repeat (4) @(posedge pclk);
    chk("term on", 1, term);
    xfer(1, AT, 0);
    repeat (4) @(posedge pclk);
    chk("term cleared", 0, term);
    $display("test termination done");
    ratio(`ECD_MODE_DIVIDED, 2, 2);
    xfer(1, AC, 32'hff);
    xfer(0, AS, 0);
    chk("fast at eight channels", 3'h3, rd[18:16]);
    xfer(1, AC, 32'h1);
    xfer(0, AS, 0);
    chk("slow at one channel", 3'h5, rd[18:16]);
    $display("test band status done");
    ratio(`ECD_MODE_DIRECT, 2, 1);
    ratio(`ECD_MODE_DIVIDED, 4, 4);
    $display("test division done");
    xfer(1, AB, `ECD_BAND_SLOW);
    run <= 1'b0;
    repeat (20) @(posedge pclk);
    n0 = rises;
    repeat (5000) @(posedge pclk);
    chk("gap holds output", n0, rises);
    xfer(0, AS, 0);
    chk("slow gap status", 4'h0, rd[19:16]);
    run <= 1'b1;
    ratio(`ECD_MODE_DIVIDED, 4, 4);
    xfer(1, AB, `ECD_BAND_FAST);
    run <= 1'b0;
    repeat (4200) @(posedge pclk);
    xfer(0, AS, 0);
    chk("fast gap flag", 4'h8, rd[19:16]);
    xfer(1, AS, 32'h0008_0000);
    xfer(0, AS, 0);
    chk("gap flag cleared", 4'h0, rd[19:16]);
    $display("test gap done");
    give_verdict();
  end
endmodule // ecd_clock_ctrl_tb_top
